/* File: hdl/crf_regfile.sv */
/*
 Core register file: two banks of data, address and frame registers, shared
 vector base, program counter, stack pointers, static base and flags.
 Assumes one clock, synchronous active-low reset, a classic Wishbone master
 and an execution unit that never writes in the same cycle as Wishbone.
*/
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.svh"
// How it works
// - Two banks of seven registers: four data, two address, frame base.
// - Four 16-bit data registers readable and writable as operands.
// - Data registers 0 and 1 split into separate high and low bytes.
// - Data 2 over data 0 and data 3 over data 1 form 32-bit pairs.
// - Two 16-bit address registers, address 1 over 0 forms 32 bits.
// - Frame base is 16 bits and feeds frame-relative addressing.
// - Vector table base is 20 bits wide.
// - Program counter is 20 bits holding the next instruction address.
// - Separate stack pointers; stack flag 0 picks interrupt, 1 user.
// - Stack flag clears on hardware ack or software interrupt 0 to 31.
// - Static base register is 16 bits wide.
// - Flag register is 11 bits with condition, bank, stack, enable, level.
// - Carry flag captures carry, borrow or shifted-out bit.
// - Zero flag set when arithmetic result is zero, else cleared.
// - Sign flag set when arithmetic result is negative, else cleared.
// - Overflow flag follows arithmetic overflow.
// - Bank flag 0 routes banked accesses to bank 0, 1 to bank 1.
// - Enable flag 0 blocks maskable interrupts, 1 allows them.
// - Enable flag clears whenever an interrupt is acknowledged.
// - Three-bit level; a request is taken only above the current level.
// - Reserved flag bits are written zero and read undefined.
module crf_regfile
   import crf_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire crf_sel_e    eu_rd_sel,
   output logic      [31:0] eu_rd_data,
   input  wire crf_wr_s     eu_wr,
   input  wire logic        pc_load,
   input  wire logic [19:0] pc_next,
   input  wire crf_alu_s    alu,
   input  wire crf_irq_s    irq,
   output logic             irq_accept,
   output logic      [10:0] flags_o
);
   crf_state_s  st;
   crf_state_s  next_st;
   logic        wb_hit;
   logic [31:0] wb_wmask;
   logic [31:0] wb_rd;
   logic [31:0] res_m;
   logic        res_neg;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------

   // Read one selected view of the register file at 32 bits.
   function automatic logic [31:0] rd_view(input crf_state_s s, input crf_sel_e sel);
      crf_bank_s b;
      logic [15:0] sp;
      b = s.bank[s.flags[`CRF_FLG_B]];
      sp = s.flags[`CRF_FLG_U] ? s.user_stack_ptr : s.irq_stack_ptr;
      unique case (sel)
         CRF_SEL_DATA0:  rd_view = {16'h0000, b.data0};
         CRF_SEL_DATA1:  rd_view = {16'h0000, b.data1};
         CRF_SEL_DATA2:  rd_view = {16'h0000, b.data2};
         CRF_SEL_DATA3:  rd_view = {16'h0000, b.data3};
         CRF_SEL_ADDR0:  rd_view = {16'h0000, b.addr0};
         CRF_SEL_ADDR1:  rd_view = {16'h0000, b.addr1};
         CRF_SEL_FRAME:  rd_view = {16'h0000, b.frame};
         CRF_SEL_VECT:   rd_view = {12'h000, s.vect};
         CRF_SEL_PC:     rd_view = {12'h000, s.pc};
         CRF_SEL_USP:    rd_view = {16'h0000, s.user_stack_ptr};
         CRF_SEL_ISP:    rd_view = {16'h0000, s.irq_stack_ptr};
         CRF_SEL_SB:     rd_view = {16'h0000, s.sb};
         CRF_SEL_FLAGS:  rd_view = {21'h000000, s.flags};
         CRF_SEL_SP:     rd_view = {16'h0000, sp};
         CRF_SEL_D0H:    rd_view = {24'h000000, b.data0[15:8]};
         CRF_SEL_D0L:    rd_view = {24'h000000, b.data0[7:0]};
         CRF_SEL_D1H:    rd_view = {24'h000000, b.data1[15:8]};
         CRF_SEL_D1L:    rd_view = {24'h000000, b.data1[7:0]};
         CRF_SEL_PAIRLO: rd_view = {b.data2, b.data0};
         CRF_SEL_PAIRHI: rd_view = {b.data3, b.data1};
         CRF_SEL_APAIR:  rd_view = {b.addr1, b.addr0};
         default:        rd_view = 32'h00000000;
      endcase
   endfunction

   // Map a Wishbone byte offset onto a selector; unmapped gives a miss.
   function automatic logic wb_map(input logic [7:0] adr, output crf_sel_e sel);
      wb_map = 1'b1;
      unique case (adr)
         `CRF_OFS_DATA0: sel = CRF_SEL_DATA0;
         `CRF_OFS_DATA1: sel = CRF_SEL_DATA1;
         `CRF_OFS_DATA2: sel = CRF_SEL_DATA2;
         `CRF_OFS_DATA3: sel = CRF_SEL_DATA3;
         `CRF_OFS_ADDR0: sel = CRF_SEL_ADDR0;
         `CRF_OFS_ADDR1: sel = CRF_SEL_ADDR1;
         `CRF_OFS_FRAME: sel = CRF_SEL_FRAME;
         `CRF_OFS_VECT:  sel = CRF_SEL_VECT;
         `CRF_OFS_PC:    sel = CRF_SEL_PC;
         `CRF_OFS_USP:   sel = CRF_SEL_USP;
         `CRF_OFS_ISP:   sel = CRF_SEL_ISP;
         `CRF_OFS_SB:    sel = CRF_SEL_SB;
         `CRF_OFS_FLAGS: sel = CRF_SEL_FLAGS;
         `CRF_OFS_SP:    sel = CRF_SEL_SP;
         default: begin
            sel = CRF_SEL_DATA0;
            wb_map = 1'b0;
         end
      endcase
   endfunction

   // Apply a write of a selected view; mask marks the bits that change in every view except the byte and pair views.
   function automatic crf_state_s wr_view(input crf_state_s s, input crf_sel_e sel,
                                          input logic [31:0] d, input logic [31:0] m);
      logic bk;
      bk = s.flags[`CRF_FLG_B];
      wr_view = s;
      unique case (sel)
         CRF_SEL_DATA0:  wr_view.bank[bk].data0 = (s.bank[bk].data0 & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_DATA1:  wr_view.bank[bk].data1 = (s.bank[bk].data1 & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_DATA2:  wr_view.bank[bk].data2 = (s.bank[bk].data2 & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_DATA3:  wr_view.bank[bk].data3 = (s.bank[bk].data3 & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_ADDR0:  wr_view.bank[bk].addr0 = (s.bank[bk].addr0 & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_ADDR1:  wr_view.bank[bk].addr1 = (s.bank[bk].addr1 & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_FRAME:  wr_view.bank[bk].frame = (s.bank[bk].frame & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_VECT:   wr_view.vect = (s.vect & ~m[19:0]) | (d[19:0] & m[19:0]);
         CRF_SEL_PC:     wr_view.pc = (s.pc & ~m[19:0]) | (d[19:0] & m[19:0]);
         CRF_SEL_USP:    wr_view.user_stack_ptr = (s.user_stack_ptr & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_ISP:    wr_view.irq_stack_ptr = (s.irq_stack_ptr & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_SB:     wr_view.sb = (s.sb & ~m[15:0]) | (d[15:0] & m[15:0]);
         CRF_SEL_FLAGS:  wr_view.flags = (s.flags & ~m[10:0]) | (d[10:0] & m[10:0]);
         CRF_SEL_SP: begin
            if (s.flags[`CRF_FLG_U]) begin
               wr_view.user_stack_ptr = (s.user_stack_ptr & ~m[15:0]) | (d[15:0] & m[15:0]);
            end else begin
               wr_view.irq_stack_ptr = (s.irq_stack_ptr & ~m[15:0]) | (d[15:0] & m[15:0]);
            end
         end
         CRF_SEL_D0H:    wr_view.bank[bk].data0[15:8] = d[7:0];
         CRF_SEL_D0L:    wr_view.bank[bk].data0[7:0] = d[7:0];
         CRF_SEL_D1H:    wr_view.bank[bk].data1[15:8] = d[7:0];
         CRF_SEL_D1L:    wr_view.bank[bk].data1[7:0] = d[7:0];
         CRF_SEL_PAIRLO: begin
            wr_view.bank[bk].data0 = d[15:0];
            wr_view.bank[bk].data2 = d[31:16];
         end
         CRF_SEL_PAIRHI: begin
            wr_view.bank[bk].data1 = d[15:0];
            wr_view.bank[bk].data3 = d[31:16];
         end
         CRF_SEL_APAIR:  begin
            wr_view.bank[bk].addr0 = d[15:0];
            wr_view.bank[bk].addr1 = d[31:16];
         end
         default:        wr_view = s;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------

   // Bus decode, execution-unit writes, flag updates and interrupt entry.
   // Later steps override earlier ones, so the interrupt entry wins over a
   // simultaneous flag write from either port.
   always_comb begin
      crf_sel_e wsel;
      wsel = CRF_SEL_DATA0;
      next_st = st;
      wb_hit = wb_map(wb_adr_i, wsel);
      wb_wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wb_rd = wb_hit ? rd_view(st, wsel) : 32'h00000000;
      next_st.wb_ack = wb_cyc_i & wb_stb_i & ~st.wb_ack;
      next_st.wb_dat = wb_rd;
      // Banked registers reached from the bus follow the bank flag too.
      // A bus write lands at the edge where the master samples ack high.
      if (wb_cyc_i && wb_stb_i && st.wb_ack && wb_we_i && wb_hit) begin
         next_st = wr_view(next_st, wsel, wb_dat_i, wb_wmask);
      end else if (eu_wr.we) begin
         next_st = wr_view(next_st, eu_wr.sel, eu_wr.data, 32'hFFFFFFFF);
      end
      if (pc_load) begin
         next_st.pc = pc_next;
      end
      if (alu.carry_upd) begin
         next_st.flags[`CRF_FLG_C] = alu.carry;
      end
      unique case (alu.size)
         2'b00:   res_m = {24'h000000, alu.result[7:0]};
         2'b01:   res_m = {16'h0000, alu.result[15:0]};
         default: res_m = alu.result;
      endcase
      unique case (alu.size)
         2'b00:   res_neg = alu.result[7];
         2'b01:   res_neg = alu.result[15];
         default: res_neg = alu.result[31];
      endcase
      if (alu.arith) begin
         next_st.flags[`CRF_FLG_Z] = (res_m == 32'h00000000);
         next_st.flags[`CRF_FLG_S] = res_neg;
         next_st.flags[`CRF_FLG_O] = alu.ovf;
      end
      // Level comparison is strict: an equal level is held off.
      next_st.irq_accept = irq.req
                           & (~irq.maskable | st.flags[`CRF_FLG_I])
                           & (irq.prio > st.flags[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO]);
      if (irq.hw_ack || irq.swi) begin
         next_st.flags[`CRF_FLG_I] = 1'b0;
      end
      if (irq.hw_ack || (irq.swi && irq.swi_num <= `CRF_SWI_MAX)) begin
         next_st.flags[`CRF_FLG_U] = 1'b0;
      end
      next_st.rd_data = rd_view(next_st, eu_rd_sel);
      if (!rst_n) begin
         next_st.flags = `CRF_FLG_RESET;
         next_st.wb_ack = 1'b0;
         next_st.wb_dat = 32'h00000000;
         next_st.rd_data = 32'h00000000;
         next_st.irq_accept = 1'b0;
         next_st.pc = 20'h00000;
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------

   // Data registers keep their contents over reset; only control resets.
   always_ff @(posedge mclk) begin
      st <= next_st;
   end

   assign wb_dat_o   = st.wb_dat;
   assign wb_ack_o   = st.wb_ack;
   assign eu_rd_data = st.rd_data;
   assign irq_accept = st.irq_accept;
   assign flags_o    = st.flags;
endmodule
`default_nettype wire

/* File: hdl/crf_defines.svh */
/*
 Offsets, field positions and reset values of the core register file.
 Assumes inclusion by bare name from the module.
*/
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH
// -----------------------------------------------------------------------------
// Wishbone register offsets (byte addresses, one word each)
// -----------------------------------------------------------------------------
`define CRF_OFS_DATA0     8'h00
`define CRF_OFS_DATA1     8'h04
`define CRF_OFS_DATA2     8'h08
`define CRF_OFS_DATA3     8'h0C
`define CRF_OFS_ADDR0     8'h10
`define CRF_OFS_ADDR1     8'h14
`define CRF_OFS_FRAME     8'h18
`define CRF_OFS_VECT      8'h1C
`define CRF_OFS_PC        8'h20
`define CRF_OFS_USP       8'h24
`define CRF_OFS_ISP       8'h28
`define CRF_OFS_SB        8'h2C
`define CRF_OFS_FLAGS     8'h30
`define CRF_OFS_SP        8'h34
// -----------------------------------------------------------------------------
// Flag register field positions
// -----------------------------------------------------------------------------
`define CRF_FLG_C         0
`define CRF_FLG_D         1
`define CRF_FLG_Z         2
`define CRF_FLG_S         3
`define CRF_FLG_B         4
`define CRF_FLG_O         5
`define CRF_FLG_I         6
`define CRF_FLG_U         7
`define CRF_FLG_IPL_LO    8
`define CRF_FLG_IPL_HI    10
`define CRF_FLG_WMASK     11'h7FF
`define CRF_FLG_RESET     11'h000
`define CRF_SWI_MAX       6'h1F
`endif

/* File: hdl/crf_pkg.sv */
/*
 Types shared by the core register file.
 Assumes the defines header is on the include path.
*/
package crf_pkg;
   // Register selector used by the execution-unit port.
   typedef enum logic [4:0] {
      CRF_SEL_DATA0  = 5'h00,
      CRF_SEL_DATA1  = 5'h01,
      CRF_SEL_DATA2  = 5'h02,
      CRF_SEL_DATA3  = 5'h03,
      CRF_SEL_ADDR0  = 5'h04,
      CRF_SEL_ADDR1  = 5'h05,
      CRF_SEL_FRAME  = 5'h06,
      CRF_SEL_VECT   = 5'h07,
      CRF_SEL_PC     = 5'h08,
      CRF_SEL_USP    = 5'h09,
      CRF_SEL_ISP    = 5'h0A,
      CRF_SEL_SB     = 5'h0B,
      CRF_SEL_FLAGS  = 5'h0C,
      CRF_SEL_SP     = 5'h0D,
      CRF_SEL_D0H    = 5'h10,
      CRF_SEL_D0L    = 5'h11,
      CRF_SEL_D1H    = 5'h12,
      CRF_SEL_D1L    = 5'h13,
      CRF_SEL_PAIRLO = 5'h14,
      CRF_SEL_PAIRHI = 5'h15,
      CRF_SEL_APAIR  = 5'h16
   } crf_sel_e;

   // One bank of seven registers.
   typedef struct packed {
      logic [15:0] data0;
      logic [15:0] data1;
      logic [15:0] data2;
      logic [15:0] data3;
      logic [15:0] addr0;
      logic [15:0] addr1;
      logic [15:0] frame;
   } crf_bank_s;

   // Execution-unit write request.
   typedef struct packed {
      logic        we;
      crf_sel_e    sel;
      logic [31:0] data;
   } crf_wr_s;

   // Flag update from the arithmetic unit.
   typedef struct packed {
      logic        arith;
      logic        carry_upd;
      logic        carry;
      logic [31:0] result;
      logic [1:0]  size;
      logic        ovf;
   } crf_alu_s;

   // Interrupt request and acknowledge inputs.
   typedef struct packed {
      logic       req;
      logic [2:0] prio;
      logic       maskable;
      logic       hw_ack;
      logic       swi;
      logic [5:0] swi_num;
   } crf_irq_s;

   // Whole state of the register file.
   typedef struct packed {
      crf_bank_s [1:0] bank;
      logic [19:0]     vect;
      logic [19:0]     pc;
      logic [15:0]     user_stack_ptr;
      logic [15:0]     irq_stack_ptr;
      logic [15:0]     sb;
      logic [10:0]     flags;
      logic [31:0]     rd_data;
      logic [31:0]     wb_dat;
      logic            wb_ack;
      logic            irq_accept;
   } crf_state_s;
endpackage

/* File: test/crf_regfile_properties.sv */
/*
 Port checker for the core register file.
 Assumes it is bound to crf_regfile and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module crf_regfile_props
   import crf_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire crf_wr_s     eu_wr,
   input wire crf_alu_s    alu,
   input wire crf_irq_s    irq,
   input wire logic        irq_accept,
   input wire logic [10:0] flags_o
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // The arithmetic update wins over any other flag writer in the cycle, yet the arithmetic checks still skip that cycle.
   sequence s_quiet;
      !(wb_cyc_i && wb_stb_i && wb_we_i) && !eu_wr.we && !irq.hw_ack && !irq.swi;
   endsequence
   sequence s_word_op;
      alu.arith && alu.size == 2'h1 ##0 s_quiet;
   endsequence
   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Bus handshake, then flag updates and interrupt entry.
   AST_WB_ACK: assert property (s_bus_req |=> wb_ack_o) else $error("bus request not acknowledged");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   AST_CARRY: assert property (alu.carry_upd ##0 s_quiet |=> flags_o[0] == $past(alu.carry))
      else $error("carry flag wrong");
   AST_ZERO: assert property (s_word_op |=> flags_o[2] == ($past(alu.result[15:0]) == 16'h0000))
      else $error("zero flag wrong");
   AST_SIGN: assert property (s_word_op |=> flags_o[3] == $past(alu.result[15]))
      else $error("sign flag wrong");
   AST_OVF: assert property (alu.arith ##0 s_quiet |=> flags_o[5] == $past(alu.ovf))
      else $error("overflow flag wrong");
   AST_HW_ENTRY: assert property (irq.hw_ack |=> flags_o[7:6] == 2'b00)
      else $error("hardware entry left flags set");
   AST_SWI_LOW: assert property (irq.swi && irq.swi_num <= 6'h1F |=> flags_o[7:6] == 2'b00)
      else $error("software entry left flags set");
   AST_SWI_HIGH: assert property (irq.swi && !irq.hw_ack && irq.swi_num > 6'h1F && !eu_wr.we
      && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(flags_o[7])) else $error("stack flag changed");
   AST_ACCEPT: assert property (1'b1 |=> irq_accept ==
      $past(irq.req && (!irq.maskable || flags_o[6]) && irq.prio > flags_o[10:8])) else $error("accept wrong");
endmodule
bind crf_regfile crf_regfile_props u_props (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
   .eu_wr, .alu, .irq, .irq_accept, .flags_o);
`default_nettype wire

/* File: test/crf_eu_model.sv */
/*
 Execution-unit model driving the register file's execution side.
 Assumes its tasks are called from one bench process.
*/
`timescale 1ns/100ps
`default_nettype none
module crf_eu_model
   import crf_pkg::*;
(
   input  wire logic        mclk,
   output crf_wr_s          eu_wr,
   output crf_sel_e         eu_rd_sel,
   output logic             pc_load,
   output logic      [19:0] pc_next,
   output crf_alu_s         alu,
   output crf_irq_s         irq
);
   // Idle: no write, no update, no request.
   initial begin
      eu_wr = '0;
      eu_rd_sel = CRF_SEL_DATA0;
      pc_load = 1'b0;
      pc_next = 20'h0;
      alu = '0;
      irq = '0;
   end
   // One request held for exactly one edge, then dropped so it never repeats.
   task automatic step(input crf_alu_s a, input crf_irq_s q, input crf_wr_s w);
      @(posedge mclk);
      alu <= a;
      irq <= q;
      eu_wr <= w;
      @(posedge mclk);
      alu <= '0;
      irq <= '0;
      eu_wr <= '0;
   endtask
   // Selector lands on one edge; the view is readable just after the next.
   task automatic rd(input crf_sel_e s);
      @(posedge mclk);
      eu_rd_sel <= s;
      @(posedge mclk);
   endtask
   task automatic jump(input logic [19:0] t);
      @(posedge mclk);
      pc_load <= 1'b1;
      pc_next <= t;
      @(posedge mclk);
      pc_load <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: test/crf_regfile_tb_top.sv */
/*
 Self-checking bench for the core register file.
 Assumes the package, the defines header and the execution-unit model.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module crf_regfile_tb_top
   import crf_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, eu_rd_data, q, d, e;
   logic        wb_ack_o, irq_accept, pc_load;
   logic [10:0] flags_o, ef;
   logic [19:0] pc_next;
   crf_wr_s     eu_wr;
   crf_sel_e    eu_rd_sel;
   crf_alu_s    alu, a;
   crf_irq_s    irq, r;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc_cnt = 0;
   int          i, b;
   logic [15:0] bk [2][7];
   logic [31:0] ev [7];
   logic [7:0]  ofs [6] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h38};
   crf_sel_e    vs [7] = '{CRF_SEL_PAIRLO, CRF_SEL_PAIRHI, CRF_SEL_APAIR, CRF_SEL_D0H, CRF_SEL_D0L,
                           CRF_SEL_D1H, CRF_SEL_D1L};
   logic [10:0] fa [5] = '{11'h340, 11'h340, 11'h300, 11'h300, 11'h740};
   logic [2:0]  pr [5] = '{3'h4, 3'h3, 3'h7, 3'h7, 3'h7};
   logic        mk [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic        ex [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

   always #2 mclk = ~mclk;

   crf_regfile u_dut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .eu_rd_sel, .eu_rd_data, .eu_wr, .pc_load, .pc_next, .alu, .irq,
      .irq_accept, .flags_o);
   crf_eu_model u_eu (.mclk, .eu_wr, .eu_rd_sel, .pc_load, .pc_next, .alu, .irq);

   // Visible width of each register; the stack offset shows a 16-bit pointer.
   function automatic logic [31:0] msk(input logic [7:0] o);
      return (o == 8'h30) ? 32'h7FF : (o == 8'h1C || o == 8'h20) ? 32'hFFFFF : 32'hFFFF;
   endfunction
   // Sign and zero of a result at the operand size, as {sign, zero}.
   function automatic logic [1:0] sz(input logic [31:0] v, input logic [1:0] s);
      if (s == 2'h0) return {v[7], v[7:0] == 8'h0};
      if (s == 2'h1) return {v[15], v[15:0] == 16'h0};
      return {v[31], v == 32'h0};
   endfunction
   // Classic single cycle; waits for ack with no timeout of its own, read data lands in q.
   task automatic wb(input logic w, input logic [7:0] o, input logic [31:0] dv);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= o;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dv;
      do begin
         @(posedge mclk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A hang is cut short well beyond the few hundred cycles the run needs.
   always @(posedge mclk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(32'hf716e9fd));
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      // Shared registers, then an unmapped hole that reads zero.
      foreach (ofs[k]) begin
         d = $urandom;
         wb(1'b1, ofs[k], d);
         wb(1'b0, ofs[k], 32'h0);
         `CHK("shared", (ofs[k] == 8'h38) ? 32'h0 : d & msk(ofs[k]), q)
      end
      d = $urandom & 32'h7FD;
      wb(1'b1, 8'h30, d);
      wb(1'b0, 8'h30, 32'h0);
      `CHK("flags", d, q)
      // Fill both banks, then read each back under its bank flag.
      for (b = 0; b < 2; b++) begin
         wb(1'b1, 8'h30, 32'(b) << 4);
         for (i = 0; i < 7; i++) begin
            bk[b][i] = 16'($urandom);
            wb(1'b1, 8'(i * 4), {16'h0, bk[b][i]});
         end
      end
      for (b = 0; b < 2; b++) begin
         wb(1'b1, 8'h30, 32'(b) << 4);
         for (i = 0; i < 7; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            `CHK("banked", {16'h0, bk[b][i]}, q)
         end
      end
      // Byte and pair views of bank 1 through the execution port.
      ev = '{{bk[1][2], bk[1][0]}, {bk[1][3], bk[1][1]}, {bk[1][5], bk[1][4]}, {24'h0, bk[1][0][15:8]},
             {24'h0, bk[1][0][7:0]}, {24'h0, bk[1][1][15:8]}, {24'h0, bk[1][1][7:0]}};
      for (i = 0; i < 7; i++) begin
         u_eu.rd(vs[i]);
         #1 `CHK("view", ev[i], eu_rd_data)
      end
      u_eu.step('0, '0, {1'b1, CRF_SEL_D1L, 32'h000000A5});
      u_eu.rd(CRF_SEL_DATA1);
      #1 `CHK("byte write", {16'h0, bk[1][1][15:8], 8'hA5}, eu_rd_data)
      e = $urandom;
      u_eu.step('0, '0, {1'b1, CRF_SEL_APAIR, e});
      u_eu.rd(CRF_SEL_ADDR1);
      #1 `CHK("pair write", {16'h0, e[31:16]}, eu_rd_data)
      u_eu.jump(d[19:0]);
      u_eu.rd(CRF_SEL_PC);
      #1 `CHK("pc", {12'h0, d[19:0]}, eu_rd_data)
      // Active stack pointer follows the stack flag.
      d = $urandom;
      e = $urandom;
      wb(1'b1, 8'h24, d);
      wb(1'b1, 8'h28, e);
      wb(1'b1, 8'h30, 32'h0);
      wb(1'b0, 8'h34, 32'h0);
      `CHK("isp active", e & 32'hFFFF, q)
      wb(1'b1, 8'h30, 32'h80);
      wb(1'b0, 8'h34, 32'h0);
      `CHK("usp active", d & 32'hFFFF, q)
      // Random operations; the first three give zero at each operand size.
      wb(1'b1, 8'h30, 32'h0);
      ef = 11'h0;
      for (i = 0; i < 24; i++) begin
         a = crf_alu_s'({$urandom, $urandom});
         if (i < 3) begin
            a.arith = 1'b1;
            a.size = 2'(i);
            a.result = 32'h1 << (8 << i);
         end
         if (a.arith) ef[3:2] = sz(a.result, a.size);
         if (a.arith) ef[5] = a.ovf;
         if (a.carry_upd) ef[0] = a.carry;
         u_eu.step(a, '0, '0);
         #1 `CHK("flags after op", ef, flags_o)
      end
      // Acceptance against enable flag and priority level, equal level refused.
      for (i = 0; i < 5; i++) begin
         wb(1'b1, 8'h30, {21'h0, fa[i]});
         r = '0;
         r.req = 1'b1;
         r.prio = pr[i];
         r.maskable = mk[i];
         u_eu.step('0, r, '0);
         #1 `CHK("accept", ex[i], irq_accept)
      end
      // Entry by hardware, software 31 and software 32.
      for (i = 0; i < 3; i++) begin
         wb(1'b1, 8'h30, 32'h0C0);
         r = '0;
         r.hw_ack = (i == 0);
         r.swi = (i > 0);
         r.swi_num = 6'(30 + i);
         u_eu.step('0, r, '0);
         #1 `CHK("entry flags", 11'(i == 2) << 7, flags_o)
      end
      // Reset in mid-run: control state clears and the first request after release is served.
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      #1 `CHK("reset flags", 11'h000, flags_o)
      `CHK("reset accept", 1'b0, irq_accept)
      wb(1'b0, 8'h20, 32'h0);
      `CHK("reset pc", 32'h0, q)
      wrap_up();
   end
endmodule
`default_nettype wire
